// ===== rtl/imbcs_pkg.sv
// Package of the indexed-mode bus-cycle sequencer: constants, kinds, bus cycle struct.
// Assumes an 8-bit core with a 16-bit address bus.
package imbcs_pkg;

    localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
    localparam logic [7:0] PAGE_PREFIX_SECOND = 8'h18;
    localparam logic [7:0] PAGE_PREFIX_CMP = 8'h1A;
    localparam logic [7:0] PAGE_PREFIX_CMP_ALT = 8'hCD;
    localparam logic [7:0] OPC_JSR_IDX = 8'hAD;
    localparam logic [7:0] OPC_JMP_IDX = 8'h6E;
    localparam logic [7:0] OPC_TST_IDX = 8'h6D;
    localparam logic [7:0] OPC_BIT_SET_OP_IDX = 8'h1C;
    localparam logic [7:0] OPC_BIT_CLEAR_OP_IDX = 8'h1D;
    localparam logic [7:0] OPC_CPD_IDX = 8'hA3;
    localparam logic [3:0] LEN_CMP = 4'h7;
    localparam logic [3:0] LEN_JSR_X = 4'h6;
    localparam logic [3:0] LEN_BIT_X = 4'h7;
    localparam logic [3:0] LEN_JMP_Y = 4'h4;
    localparam logic [3:0] LEN_RMW_Y = 4'h7;
    localparam logic [3:0] LEN_ACC_Y = 4'h5;

    // Kind of indexed instruction being sequenced
    typedef enum logic [3:0] {
        KIND_CMP = 4'h0,
        KIND_JSR_X = 4'h1,
        KIND_BIT_X = 4'h2,
        KIND_JMP_Y = 4'h3,
        KIND_RMW_Y = 4'h4,
        KIND_TST_Y = 4'h5,
        KIND_ACC_Y = 4'h6,
        KIND_STA_Y = 4'h7,
        KIND_OTHER = 4'h8
    } imbcs_kind_type;

    // Data bus meaning for the current cycle
    typedef enum logic [3:0] {
        DATA_OPCODE = 4'h0,
        DATA_SECOND = 4'h1,
        DATA_OFFSET = 4'h2,
        DATA_IRRELEVANT = 4'h3,
        DATA_OPERAND = 4'h4,
        DATA_OPERAND_LOW = 4'h5,
        DATA_MASK = 4'h6,
        DATA_RESULT = 4'h7,
        DATA_RET_LOW = 4'h8,
        DATA_RET_HIGH = 4'h9,
        DATA_ACCUM = 4'hA,
        DATA_FIRST_OPCODE = 4'hB
    } imbcs_data_type;

    typedef struct packed {
        logic [15:0] addr;
        logic rw;
        imbcs_data_type meaning;
    } imbcs_cycle_type;

endpackage

// ===== rtl/imbcs_sequencer.sv
// Indexed-mode bus-cycle sequencer: drives address, R/W and data meaning per cycle.
// Assumes memory answers reads in the same cycle on DATA_IN; START and kind come
// from the core's opcode predecoder on the same clock.
// Overview of operation
// - Prefixed double compare via first index: seven reads, dummy, high, low, dummy.
// - First-index subroutine jump: six cycles, target opcode fetched in cycle four.
// - Subroutine jump ends writing return low at SP, high at SP minus one.
// - First-index bit set/clear: seven cycles, mask at opcode plus two, write last.
// - Second-index forms start prefix, second byte, offset, then dummy at FFFF.
// - Second-index jump: four reads, no operand access.
// - Second-index read-modify-write seven cycles; test replaces final write by dummy.
// - Second-index accumulator ops: five cycles, operand read in cycle five.
// - Second-index accumulator stores: five cycles beginning with the prefix fetch.
`timescale 1ns/1ns
module imbcs_sequencer (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic START,
    input wire imbcs_pkg::imbcs_kind_type KIND,
    input wire logic [15:0] OPCODE_ADDR,
    input wire logic [15:0] INDEX_X,
    input wire logic [15:0] INDEX_Y,
    input wire logic [15:0] STACK_PTR,
    input wire logic [7:0] DATA_IN,
    output logic [15:0] ADDR,
    output logic RW,
    output imbcs_pkg::imbcs_data_type MEANING,
    output logic BUSY,
    output logic DONE,
    output logic NEXT_FETCH
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } imbcs_state_type;

    imbcs_state_type state;
    imbcs_pkg::imbcs_kind_type kind;
    logic [3:0] step;
    logic [15:0] opc_addr;
    logic [7:0] offset;
    logic [15:0] eff_addr;
    logic use_y;
    logic last;
    imbcs_pkg::imbcs_cycle_type cycle;

    // Offset is unsigned, added to the selected index
    assign eff_addr = (use_y ? INDEX_Y : INDEX_X) + {8'h00, offset};

    imbcs_step_decode u_decode (
        .kind(kind),
        .step(step),
        .opc_addr(opc_addr),
        .eff_addr(eff_addr),
        .stack_ptr(STACK_PTR),
        .cycle(cycle),
        .last(last)
    );

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state <= ST_IDLE;
            step <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (START) begin
                        state <= ST_RUN;
                        step <= 4'h1;
                    end
                end
                ST_RUN: begin
                    if (last) begin
                        state <= ST_IDLE;
                        step <= 4'h0;
                    end else begin
                        step <= step + 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    step <= 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            kind <= imbcs_pkg::KIND_OTHER;
            opc_addr <= 16'h0000;
            use_y <= 1'b0;
        end else if (state == ST_IDLE && START) begin
            kind <= KIND;
            opc_addr <= OPCODE_ADDR;
            // Compare form is the first index; the rest of the prefixed set is second
            use_y <= !(KIND == imbcs_pkg::KIND_CMP || KIND == imbcs_pkg::KIND_JSR_X
                || KIND == imbcs_pkg::KIND_BIT_X);
        end
    end

    // Capture the offset when its byte is on the bus
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            offset <= 8'h00;
        end else if (state == ST_RUN && cycle.meaning == imbcs_pkg::DATA_OFFSET) begin
            offset <= DATA_IN;
        end
    end

    // Bus outputs combinational so each cycle's address matches its step
    always_comb begin
        if (state == ST_RUN) begin
            ADDR = cycle.addr;
            RW = cycle.rw;
            MEANING = cycle.meaning;
        end else begin
            ADDR = OPCODE_ADDR;
            RW = 1'b1;
            MEANING = imbcs_pkg::DATA_OPCODE;
        end
    end

    assign BUSY = (state == ST_RUN);
    assign DONE = (state == ST_RUN) && last;
    assign NEXT_FETCH = (state == ST_IDLE);
endmodule // imbcs_sequencer

// ===== rtl/imbcs_step_decode.sv
// Step decoder: maps instruction kind and cycle number to address select, R/W and meaning.
// Assumes the caller supplies the live address sources each cycle.
`timescale 1ns/1ns
module imbcs_step_decode (
    input wire imbcs_pkg::imbcs_kind_type kind,
    input wire logic [3:0] step,
    input wire logic [15:0] opc_addr,
    input wire logic [15:0] eff_addr,
    input wire logic [15:0] stack_ptr,
    output imbcs_pkg::imbcs_cycle_type cycle,
    output logic last
);
    function automatic imbcs_pkg::imbcs_cycle_type mk(input logic [15:0] a, input logic rw,
            input imbcs_pkg::imbcs_data_type m);
        imbcs_pkg::imbcs_cycle_type c;
        c.addr = a;
        c.rw = rw;
        c.meaning = m;
        return c;
    endfunction

    logic [15:0] dummy;
    assign dummy = imbcs_pkg::DUMMY_ADDR;

    always_comb begin
        cycle = mk(dummy, 1'b1, imbcs_pkg::DATA_IRRELEVANT);
        last = 1'b0;
        case (kind)
            imbcs_pkg::KIND_JSR_X: begin
                case (step)
                    4'h1: cycle = mk(opc_addr, 1'b1, imbcs_pkg::DATA_OPCODE);
                    4'h2: cycle = mk(opc_addr + 16'h0001, 1'b1, imbcs_pkg::DATA_OFFSET);
                    4'h3: cycle = mk(dummy, 1'b1, imbcs_pkg::DATA_IRRELEVANT);
                    4'h4: cycle = mk(eff_addr, 1'b1, imbcs_pkg::DATA_FIRST_OPCODE);
                    4'h5: cycle = mk(stack_ptr, 1'b0, imbcs_pkg::DATA_RET_LOW);
                    default: cycle = mk(stack_ptr - 16'h0001, 1'b0, imbcs_pkg::DATA_RET_HIGH);
                endcase
                last = (step == imbcs_pkg::LEN_JSR_X);
            end
            imbcs_pkg::KIND_BIT_X: begin
                case (step)
                    4'h1: cycle = mk(opc_addr, 1'b1, imbcs_pkg::DATA_OPCODE);
                    4'h2: cycle = mk(opc_addr + 16'h0001, 1'b1, imbcs_pkg::DATA_OFFSET);
                    4'h4: cycle = mk(eff_addr, 1'b1, imbcs_pkg::DATA_OPERAND);
                    4'h5: cycle = mk(opc_addr + 16'h0002, 1'b1, imbcs_pkg::DATA_MASK);
                    4'h7: cycle = mk(eff_addr, 1'b0, imbcs_pkg::DATA_RESULT);
                    default: cycle = mk(dummy, 1'b1, imbcs_pkg::DATA_IRRELEVANT);
                endcase
                last = (step == imbcs_pkg::LEN_BIT_X);
            end
            default: begin
                // Two-byte opcode forms: prefix, second byte, offset, dummy
                case (step)
                    4'h1: cycle = mk(opc_addr, 1'b1, imbcs_pkg::DATA_OPCODE);
                    4'h2: cycle = mk(opc_addr + 16'h0001, 1'b1, imbcs_pkg::DATA_SECOND);
                    4'h3: cycle = mk(opc_addr + 16'h0002, 1'b1, imbcs_pkg::DATA_OFFSET);
                    4'h4: cycle = mk(dummy, 1'b1, imbcs_pkg::DATA_IRRELEVANT);
                    4'h5: begin
                        if (kind == imbcs_pkg::KIND_STA_Y) begin
                            cycle = mk(eff_addr, 1'b0, imbcs_pkg::DATA_ACCUM);
                        end else begin
                            cycle = mk(eff_addr, 1'b1, imbcs_pkg::DATA_OPERAND);
                        end
                    end
                    4'h6: begin
                        if (kind == imbcs_pkg::KIND_CMP) begin
                            cycle = mk(eff_addr + 16'h0001, 1'b1,
                                imbcs_pkg::DATA_OPERAND_LOW);
                        end else begin
                            cycle = mk(dummy, 1'b1, imbcs_pkg::DATA_IRRELEVANT);
                        end
                    end
                    4'h7: begin
                        if (kind == imbcs_pkg::KIND_RMW_Y) begin
                            cycle = mk(eff_addr, 1'b0, imbcs_pkg::DATA_RESULT);
                        end else begin
                            cycle = mk(dummy, 1'b1, imbcs_pkg::DATA_IRRELEVANT);
                        end
                    end
                    default: cycle = mk(dummy, 1'b1, imbcs_pkg::DATA_IRRELEVANT);
                endcase
                case (kind)
                    imbcs_pkg::KIND_CMP: last = (step == imbcs_pkg::LEN_CMP);
                    imbcs_pkg::KIND_JMP_Y: last = (step == imbcs_pkg::LEN_JMP_Y);
                    imbcs_pkg::KIND_RMW_Y: last = (step == imbcs_pkg::LEN_RMW_Y);
                    imbcs_pkg::KIND_TST_Y: last = (step == imbcs_pkg::LEN_RMW_Y);
                    imbcs_pkg::KIND_ACC_Y: last = (step == imbcs_pkg::LEN_ACC_Y);
                    imbcs_pkg::KIND_STA_Y: last = (step == imbcs_pkg::LEN_ACC_Y);
                    default: last = 1'b1;
                endcase
            end
        endcase
    end
endmodule // imbcs_step_decode

// ===== sim/imbcs_mem_model.sv
// Memory and peripheral bus model answering reads in the same cycle.
// Assumes ADDR and RW come combinationally from the sequencer.
`timescale 1ns/1ns
module imbcs_mem_model (
    input wire logic [15:0] addr,
    input wire logic rw,
    input wire logic [7:0] salt,
    output logic [7:0] data
);
    // Byte tied to address, so a wrong offset source moves the operand
    // No stale byte during writes: pattern toggles with address
    assign data = rw ? (addr[7:0] ^ salt) : (8'h5A ^ {8{addr[0]}});
endmodule // imbcs_mem_model

// ===== sim/imbcs_sequencer_sva.sv
// Checker of the indexed-mode bus-cycle sequencer, bound to its top ports.
// Assumes OPCODE_ADDR and the index registers hold still while a sequence runs.
`timescale 1ns/1ns
module imbcs_sequencer_sva (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic START,
    input wire imbcs_pkg::imbcs_kind_type KIND,
    input wire logic [15:0] OPCODE_ADDR,
    input wire logic [15:0] INDEX_X,
    input wire logic [15:0] INDEX_Y,
    input wire logic [15:0] STACK_PTR,
    input wire logic [7:0] DATA_IN,
    input wire logic [15:0] ADDR,
    input wire logic RW,
    input wire imbcs_pkg::imbcs_data_type MEANING,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic NEXT_FETCH
);
    logic tk;
    assign tk = !BUSY && START;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    chk_idle_fetch: assert property (!BUSY |-> ADDR == OPCODE_ADDR && RW && NEXT_FETCH)
        else $error("idle cycle is not an opcode fetch");
    chk_done_ends: assert property (DONE |=> !BUSY)
        else $error("sequence runs past its last cycle");
    chk_cmp_dummy: assert property (tk && KIND == imbcs_pkg::KIND_CMP |=>
        RW[*3] ##1 ADDR == 16'hFFFF ##3 (ADDR == 16'hFFFF && RW && DONE))
        else $error("compare sequence wrong");
    chk_jsr_stack: assert property (tk && KIND == imbcs_pkg::KIND_JSR_X |=>
        RW[*4] ##1 (!RW && ADDR == STACK_PTR) ##1 (!RW && DONE && ADDR == STACK_PTR - 16'h0001))
        else $error("subroutine jump stack writes wrong");
    chk_rmw_write: assert property (tk && KIND inside {imbcs_pkg::KIND_BIT_X,
        imbcs_pkg::KIND_RMW_Y} |=> (RW && !DONE)[*6] ##1 (!RW && DONE))
        else $error("modify write not in cycle seven");
    chk_y_prefix: assert property (tk && KIND inside {imbcs_pkg::KIND_JMP_Y,
        imbcs_pkg::KIND_RMW_Y, imbcs_pkg::KIND_TST_Y, imbcs_pkg::KIND_ACC_Y,
        imbcs_pkg::KIND_STA_Y} |=> ADDR == OPCODE_ADDR ##1 ADDR == OPCODE_ADDR + 16'h0001
        ##1 ADDR == OPCODE_ADDR + 16'h0002 ##1 ADDR == 16'hFFFF)
        else $error("second index prefix order wrong");
    chk_jmp_len: assert property (tk && KIND == imbcs_pkg::KIND_JMP_Y |=>
        (RW && !DONE)[*3] ##1 (RW && DONE))
        else $error("jump length wrong");
    chk_tst_read: assert property (tk && KIND == imbcs_pkg::KIND_TST_Y |=>
        (RW && !DONE)[*6] ##1 (RW && DONE && ADDR == 16'hFFFF))
        else $error("test instruction end wrong");
    chk_acc_len: assert property (tk && KIND == imbcs_pkg::KIND_ACC_Y |=>
        (RW && !DONE)[*4] ##1 (RW && DONE))
        else $error("accumulator op length wrong");
    chk_sta_len: assert property (tk && KIND == imbcs_pkg::KIND_STA_Y |=>
        RW[*4] ##1 (!RW && DONE))
        else $error("store length wrong");
    cover property (tk && KIND == imbcs_pkg::KIND_JSR_X);
    cover property (DONE ##1 tk);
    cover property (BUSY && !DONE && START);
endmodule // imbcs_sequencer_sva
bind imbcs_sequencer imbcs_sequencer_sva imbcs_sequencer_sva_inst (.CLOCK(CLOCK), .RST(RST),
    .START(START), .KIND(KIND), .OPCODE_ADDR(OPCODE_ADDR), .INDEX_X(INDEX_X),
    .INDEX_Y(INDEX_Y), .STACK_PTR(STACK_PTR), .DATA_IN(DATA_IN), .ADDR(ADDR), .RW(RW),
    .MEANING(MEANING), .BUSY(BUSY), .DONE(DONE), .NEXT_FETCH(NEXT_FETCH));

// ===== sim/tb_top.sv
// Testbench of the indexed-mode bus-cycle sequencer with expected-cycle queue.
// Assumes the memory model answers reads in the same cycle.
`timescale 1ns/1ns
module tb_top;
    logic CLOCK = 0, RST = 1, START = 0, RW, BUSY, DONE, NEXT_FETCH;
    imbcs_pkg::imbcs_kind_type KIND = imbcs_pkg::KIND_OTHER;
    imbcs_pkg::imbcs_data_type MEANING;
    logic [15:0] OPCODE_ADDR = 0, INDEX_X = 0, INDEX_Y = 0, STACK_PTR = 0, ADDR;
    logic [7:0] DATA_IN, salt = 0;
    int failures = 0, check_count = 0, seed = 39192;
    logic [17:0] expq[$];
    always #5 CLOCK = ~CLOCK;
    imbcs_sequencer imbcs_sequencer_inst (.CLOCK(CLOCK), .RST(RST), .START(START), .KIND(KIND),
        .OPCODE_ADDR(OPCODE_ADDR), .INDEX_X(INDEX_X), .INDEX_Y(INDEX_Y),
        .STACK_PTR(STACK_PTR), .DATA_IN(DATA_IN), .ADDR(ADDR), .RW(RW), .MEANING(MEANING),
        .BUSY(BUSY), .DONE(DONE), .NEXT_FETCH(NEXT_FETCH));
    imbcs_mem_model imbcs_mem_model_inst (.addr(ADDR), .rw(RW), .salt(salt), .data(DATA_IN));
    task check(input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task p(input logic [15:0] a, input logic r);
        expq.push_back({a, r, 1'b0});
    endtask
    // One instruction of kind index i; poke raises START again in the first busy cycle only
    task run(input int i, input logic poke);
        logic [15:0] opc, eff, a, dm;
        int n;
        @(posedge CLOCK);
        #1;
        {OPCODE_ADDR, INDEX_X} = {$random(seed)};
        {INDEX_Y, STACK_PTR} = {$random(seed)};
        salt = $random(seed);
        KIND = imbcs_pkg::imbcs_kind_type'(i);
        START = 1'b1;
        opc = OPCODE_ADDR;
        dm = imbcs_pkg::DUMMY_ADDR;
        a = opc + ((i == 1 || i == 2) ? 16'h0001 : 16'h0002);
        eff = ((i <= 2) ? INDEX_X : INDEX_Y) + {8'h00, a[7:0] ^ salt};
        p(opc, 1'b1);
        case (i)
            0: begin
                p(opc + 16'h0001, 1'b1); p(opc + 16'h0002, 1'b1); p(dm, 1'b1);
                p(eff, 1'b1); p(eff + 16'h0001, 1'b1); p(dm, 1'b1);
            end
            1: begin
                p(opc + 16'h0001, 1'b1); p(dm, 1'b1); p(eff, 1'b1);
                p(STACK_PTR, 1'b0); p(STACK_PTR - 16'h0001, 1'b0);
            end
            2: begin
                p(opc + 16'h0001, 1'b1); p(dm, 1'b1); p(eff, 1'b1);
                p(opc + 16'h0002, 1'b1); p(dm, 1'b1); p(eff, 1'b0);
            end
            8: ;
            default: begin
                p(opc + 16'h0001, 1'b1); p(opc + 16'h0002, 1'b1); p(dm, 1'b1);
                if (i != 3) p(eff, i != 7);
                if (i == 4 || i == 5) begin
                    p(dm, 1'b1); p((i == 4) ? eff : dm, i == 5);
                end
            end
        endcase
        expq[expq.size() - 1][0] = 1'b1;
        @(posedge CLOCK);
        #1;
        START = poke;
        KIND = imbcs_pkg::KIND_JMP_Y;
        n = 0;
        while (DONE !== 1'b1 && n < 20) begin
            @(posedge CLOCK);
            #1;
            START = 1'b0;
            n++;
        end
        if (n == 20) check(18'h00000, 18'h00001);
    endtask
    always @(negedge CLOCK) begin
        if (RST === 1'b0 && BUSY === 1'b1) begin
            if (expq.size() == 0) check({ADDR, RW, DONE}, 18'h3FFFF);
            else check({ADDR, RW, DONE}, expq.pop_front());
        end else if (RST === 1'b0) begin
            check({ADDR, RW, NEXT_FETCH}, {OPCODE_ADDR, 2'b11});
        end
    end
    task final_report;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge CLOCK);
        #1;
        RST = 1'b0;
        // Back to back: each START falls in the idle cycle after DONE
        for (int i = 0; i < 27; i++) run(i % 9, 1'b0);
        run(4, 1'b1);
        repeat (3) @(posedge CLOCK);
        final_report;
    end
    initial begin
        #100000;
        failures++;
        final_report;
    end
endmodule // tb_top
